// *** inc/pll_cfg_pkg.sv ***
package pll_cfg_pkg;
	// Register offsets
	localparam logic [7:0] OFS_FREQ_SEL    = 8'h00;
	localparam logic [7:0] OFS_MN_ENABLE   = 8'h0A;
	localparam logic [7:0] OFS_REF_N_HIGH  = 8'h0F;
	localparam logic [7:0] OFS_REF_N_LOW   = 8'h10;
	localparam logic [7:0] OFS_SPREAD_LOW  = 8'h11;
	localparam logic [7:0] OFS_SPREAD_HIGH = 8'h12;
	localparam logic [7:0] OFS_CPU_LINK    = 8'h13;
	localparam logic [7:0] OFS_REF_DIV     = 8'h14;
	localparam logic [7:0] OFS_TEST        = 8'h15;
	// Field positions
	localparam int FREQ_SOURCE_BIT = 7;
	localparam int MN_ENABLE_BIT  = 7;
	localparam int N_BIT8_POS     = 7;
	localparam int N_BIT9_POS     = 6;
	localparam int STRAP_WIDTH    = 5;
	// Divider offsets of the VCO equation
	localparam logic [10:0] N_OFFSET = 11'h008;
	localparam logic [6:0]  M_OFFSET = 7'h02;
	// Reset values and write masks
	localparam logic [7:0] RESET_ZERO    = 8'h00;
	localparam logic [7:0] RESET_REF_DIV = 8'h01;
	localparam logic [7:0] RESET_CPU_LNK = 8'h11;
	localparam logic [7:0] REF_DIV_RSVD  = 8'hF0;
	localparam logic [7:0] SPREAD_RO     = 8'h80;
	// Power-on reset hold, in ns, and its cycle count
	localparam int CLOCK_NS    = 10;
	localparam int POR_TIME_NS = 1000;
	localparam int POR_CYCLES  = (POR_TIME_NS + CLOCK_NS - 1) / CLOCK_NS;
	// Register bus request
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;
	// Derived configuration
	typedef struct packed {
		logic [10:0] n_total;
		logic [6:0]  m_total;
		logic [14:0] spread_percent_code;
		logic [3:0]  processor_clock_divider;
		logic [3:0]  link_clock_divider;
		logic [4:0]  pci_divider;
		logic [3:0]  serdes_ref_output_divider;
	} clk_cfg_t;
	typedef enum logic [1:0] {ST_SAMPLE, ST_LOAD, ST_RUN} strap_state_t;
endpackage

// *** src/pll_divider_spread_config.sv ***
`timescale 1ns/1ps
module pll_divider_spread_config (
	// Clock and reset
	input  wire logic                   i_clock,
	input  wire logic                   i_resetn,
	// Register port
	input  wire pll_cfg_pkg::reg_req_t  i_req,
	input  wire logic                   i_req_valid,
	output logic [7:0]                  o_rdata,
	// Strap pins
	input  wire logic [4:0]             i_strap_in,
	input  wire logic [4:0]             i_clk_drive,
	output logic [4:0]                  o_strap_out,
	output logic [4:0]                  o_strap_oe,
	// Derived configuration
	output pll_cfg_pkg::clk_cfg_t       o_cfg,
	output logic [3:0]                  o_freq_select
);
	pll_cfg_pkg::strap_state_t state_q;
	logic [9:0]  por_cnt_q;
	logic [4:0]  strap_q;
	logic [7:0]  fsel_q, mnen_q, nhigh_q, nlow_q, spl_q, sph_q, cpulnk_q, refdiv_q, test_q;
	logic        wr_ok;
	logic        mn_wr;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = i_req_valid && i_req.wr && (a == ofs);
	endfunction

	// Straps sampled while power-on reset runs, then released to outputs
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			state_q   <= pll_cfg_pkg::ST_SAMPLE;
			por_cnt_q <= '0;
			strap_q   <= '0;
		end else begin
			case (state_q)
				pll_cfg_pkg::ST_SAMPLE: begin
					strap_q   <= i_strap_in;
					por_cnt_q <= por_cnt_q + 10'(1);
					if (por_cnt_q == 10'(pll_cfg_pkg::POR_CYCLES - 1)) begin
						state_q <= pll_cfg_pkg::ST_LOAD;
					end
				end
				pll_cfg_pkg::ST_LOAD: state_q <= pll_cfg_pkg::ST_RUN;
				pll_cfg_pkg::ST_RUN:  state_q <= pll_cfg_pkg::ST_RUN;
				default:              state_q <= pll_cfg_pkg::ST_SAMPLE;
			endcase
		end
	end

	// Latch follows the pins only while sampling; a running clock must never reach it
	chk_strap_take: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(state_q == pll_cfg_pkg::ST_SAMPLE) |=> strap_q == $past(i_strap_in))
		else $error("Strap latch missed pin level");
	chk_strap_freeze: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(state_q != pll_cfg_pkg::ST_SAMPLE) |=> $stable(strap_q))
		else $error("Strap latch changed after sampling");

	// Pins drive clocks only after reset, so straps never fight the load
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			o_strap_oe  <= '0;
			o_strap_out <= '0;
		end else begin
			o_strap_oe  <= {5{state_q == pll_cfg_pkg::ST_RUN}};
			o_strap_out <= (state_q == pll_cfg_pkg::ST_RUN) ? i_clk_drive : '0;
		end
	end

	// Once running, every pin is driven and carries its clock pattern
	chk_pin_on: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(state_q == pll_cfg_pkg::ST_RUN)
		|=> (o_strap_oe == '1) && (o_strap_out == $past(i_clk_drive)))
		else $error("Strap pin not driving its clock");

	assign wr_ok = (state_q == pll_cfg_pkg::ST_RUN);
	assign mn_wr = wr_ok && mnen_q[pll_cfg_pkg::MN_ENABLE_BIT];

	// Control registers
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			fsel_q   <= pll_cfg_pkg::RESET_ZERO;
			mnen_q   <= pll_cfg_pkg::RESET_ZERO;
			spl_q    <= pll_cfg_pkg::RESET_ZERO;
			sph_q    <= pll_cfg_pkg::RESET_ZERO;
			cpulnk_q <= pll_cfg_pkg::RESET_CPU_LNK;
			refdiv_q <= pll_cfg_pkg::RESET_REF_DIV;
			test_q   <= pll_cfg_pkg::RESET_ZERO;
		end else if (wr_ok) begin
			if (hit(i_req.addr, pll_cfg_pkg::OFS_FREQ_SEL)) fsel_q <= i_req.wdata;
			if (hit(i_req.addr, pll_cfg_pkg::OFS_MN_ENABLE)) mnen_q <= i_req.wdata;
			if (hit(i_req.addr, pll_cfg_pkg::OFS_SPREAD_LOW)) spl_q <= i_req.wdata;
			if (hit(i_req.addr, pll_cfg_pkg::OFS_SPREAD_HIGH)) begin
				sph_q <= i_req.wdata & ~pll_cfg_pkg::SPREAD_RO;
			end
			if (hit(i_req.addr, pll_cfg_pkg::OFS_CPU_LINK)) cpulnk_q <= i_req.wdata;
			if (hit(i_req.addr, pll_cfg_pkg::OFS_REF_DIV)) begin
				refdiv_q <= i_req.wdata & ~pll_cfg_pkg::REF_DIV_RSVD;
			end
			if (hit(i_req.addr, pll_cfg_pkg::OFS_TEST)) test_q <= i_req.wdata;
		end
	end

	// Writes before the run state are refused; writable fields store what was sent
	chk_early_write: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(state_q != pll_cfg_pkg::ST_RUN) |=> $stable(cpulnk_q) && $stable(refdiv_q))
		else $error("Register written before run state");
	chk_ref_take: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(wr_ok && i_req_valid && i_req.wr && i_req.addr == pll_cfg_pkg::OFS_REF_DIV)
		|=> refdiv_q[3:0] == $past(i_req.wdata[3:0]))
		else $error("Output divider write lost");
	chk_spread_take: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(wr_ok && i_req_valid && i_req.wr && i_req.addr == pll_cfg_pkg::OFS_SPREAD_HIGH)
		|=> sph_q[6:0] == $past(i_req.wdata[6:0]))
		else $error("Spread code write lost");

	// Divider registers default from the straps once sampling ends
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			nhigh_q <= pll_cfg_pkg::RESET_ZERO;
			nlow_q  <= pll_cfg_pkg::RESET_ZERO;
		end else if (state_q == pll_cfg_pkg::ST_LOAD) begin
			nhigh_q <= {3'h0, strap_q};
			nlow_q  <= {3'h0, strap_q};
		end else if (mn_wr) begin
			if (hit(i_req.addr, pll_cfg_pkg::OFS_REF_N_HIGH)) nhigh_q <= i_req.wdata;
			if (hit(i_req.addr, pll_cfg_pkg::OFS_REF_N_LOW)) nlow_q <= i_req.wdata;
		end
	end

	// Divider bytes move only through an enabled write or the strap load
	chk_n_write: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(mn_wr && i_req_valid && i_req.wr && i_req.addr == pll_cfg_pkg::OFS_REF_N_LOW)
		|=> nlow_q == $past(i_req.wdata))
		else $error("Feedback divider write lost");
	chk_nhigh_gate: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(state_q == pll_cfg_pkg::ST_RUN && !mnen_q[pll_cfg_pkg::MN_ENABLE_BIT])
		|=> $stable(nhigh_q))
		else $error("Divider high byte changed without enable");

	// Read mux, unmapped offsets read zero
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rdata <= '0;
		end else begin
			case (i_req.addr)
				pll_cfg_pkg::OFS_FREQ_SEL:    o_rdata <= fsel_q;
				pll_cfg_pkg::OFS_MN_ENABLE:   o_rdata <= mnen_q;
				pll_cfg_pkg::OFS_REF_N_HIGH:  o_rdata <= nhigh_q;
				pll_cfg_pkg::OFS_REF_N_LOW:   o_rdata <= nlow_q;
				pll_cfg_pkg::OFS_SPREAD_LOW:  o_rdata <= spl_q;
				pll_cfg_pkg::OFS_SPREAD_HIGH: o_rdata <= sph_q;
				pll_cfg_pkg::OFS_CPU_LINK:    o_rdata <= cpulnk_q;
				pll_cfg_pkg::OFS_REF_DIV:     o_rdata <= refdiv_q;
				pll_cfg_pkg::OFS_TEST:        o_rdata <= test_q;
				default:                      o_rdata <= '0;
			endcase
		end
	end

	// Derived settings; the PCI divider is the link divider doubled
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			o_cfg         <= '0;
			o_freq_select <= '0;
		end else begin
			o_cfg.n_total <= {1'b0, nhigh_q[pll_cfg_pkg::N_BIT9_POS],
				nhigh_q[pll_cfg_pkg::N_BIT8_POS], nlow_q} + pll_cfg_pkg::N_OFFSET;
			o_cfg.m_total <= {1'b0, nhigh_q[5:0]} + pll_cfg_pkg::M_OFFSET;
			o_cfg.spread_percent_code       <= {sph_q[6:0], spl_q};
			o_cfg.processor_clock_divider   <= cpulnk_q[7:4];
			o_cfg.link_clock_divider        <= cpulnk_q[3:0];
			o_cfg.pci_divider               <= {cpulnk_q[3:0], 1'b0};
			o_cfg.serdes_ref_output_divider <= refdiv_q[3:0];
			o_freq_select <= fsel_q[pll_cfg_pkg::FREQ_SOURCE_BIT] ? fsel_q[3:0]
				: strap_q[3:0];
		end
	end

	// Derived outputs lag their registers by one edge, so checks skip the edge after reset
	chk_pci_double: assert property (@(posedge i_clock) disable iff (!i_resetn)
		$past(i_resetn) |-> o_cfg.pci_divider == {$past(cpulnk_q[3:0]), 1'b0})
		else $error("PCI divider not twice link divider");
	chk_cpu_div: assert property (@(posedge i_clock) disable iff (!i_resetn)
		$past(i_resetn) |-> o_cfg.processor_clock_divider == $past(cpulnk_q[7:4]))
		else $error("Processor divider not from its register");
	chk_pin_dir: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(state_q != pll_cfg_pkg::ST_RUN) |=> o_strap_oe == '0)
		else $error("Strap pin driven before reset end");
	chk_spread_ro: assert property (@(posedge i_clock) disable iff (!i_resetn)
		sph_q[7] == 1'b0)
		else $error("Spread high bit 7 not zero");
	chk_rsvd_zero: assert property (@(posedge i_clock) disable iff (!i_resetn)
		refdiv_q[7:4] == 4'h0)
		else $error("Reserved divider bits set");
	chk_mn_gate: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(state_q == pll_cfg_pkg::ST_RUN && !mnen_q[pll_cfg_pkg::MN_ENABLE_BIT]) |=> $stable(nlow_q))
		else $error("Divider changed without enable");
	chk_strap_load: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(state_q == pll_cfg_pkg::ST_LOAD) |=> nlow_q == {3'h0, $past(strap_q)})
		else $error("Divider default not from straps");
	chk_freq_source: assert property (@(posedge i_clock) disable iff (!i_resetn)
		!fsel_q[pll_cfg_pkg::FREQ_SOURCE_BIT] && $stable(strap_q) && $stable(fsel_q)
		|=> o_freq_select == $past(strap_q[3:0]))
		else $error("Frequency not from straps");
	chk_freq_prog: assert property (@(posedge i_clock) disable iff (!i_resetn)
		fsel_q[pll_cfg_pkg::FREQ_SOURCE_BIT] |=> o_freq_select == $past(fsel_q[3:0]))
		else $error("Frequency not from register bits");
	chk_spread_code: assert property (@(posedge i_clock) disable iff (!i_resetn)
		$past(i_resetn) |-> o_cfg.spread_percent_code == {$past(sph_q[6:0]), $past(spl_q)})
		else $error("Spread code not from its bytes");
	chk_vco_n: assert property (@(posedge i_clock) disable iff (!i_resetn)
		$past(i_resetn) |-> o_cfg.n_total == {1'b0, $past(nhigh_q[pll_cfg_pkg::N_BIT9_POS]),
		$past(nhigh_q[pll_cfg_pkg::N_BIT8_POS]), $past(nlow_q)} + pll_cfg_pkg::N_OFFSET)
		else $error("N total wrong");
	chk_m_total: assert property (@(posedge i_clock) disable iff (!i_resetn)
		$past(i_resetn) |-> o_cfg.m_total == $past(nhigh_q[5:0]) + pll_cfg_pkg::M_OFFSET)
		else $error("M total wrong");
endmodule

// *** testbench/strap_board_model.sv ***
`timescale 1ns/1ps
// Board strap resistors: each pin rests at its resistor level until the device drives it
module strap_board_model #(
	parameter logic [4:0] PULL = 5'h16
) (
	// Device side of the pins
	input  wire logic [4:0] i_out,
	input  wire logic [4:0] i_oe,
	// Pin level seen by everyone
	output logic [4:0]      o_pin
);
	// Resistor level holds the pin steady while the latch samples
	always_comb begin
		for (int k = 0; k < 5; k++) begin
			o_pin[k] = i_oe[k] ? i_out[k] : PULL[k];
		end
	end
endmodule

// *** testbench/tb.sv ***
`timescale 1ns/1ps
module tb;
	localparam logic [4:0] PULL = 5'h16;
	logic                  clock;
	logic                  resetn;
	logic                  vld;
	pll_cfg_pkg::reg_req_t req;
	logic [7:0]            rdata;
	logic [4:0]            pin;
	logic [4:0]            clk_pattern;
	logic [4:0]            pattern_seen;
	logic [4:0]            sout;
	logic [4:0]            soe;
	pll_cfg_pkg::clk_cfg_t cfg;
	logic [3:0]            fsel;
	int                    fail_count;
	int                    check_count;
	// Clock and a busy pattern for the strap outputs to carry
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) clk_pattern <= #1 clk_pattern + 5'h01;
	pll_divider_spread_config i_pll_divider_spread_config (.i_clock(clock), .i_resetn(resetn),
		.i_req(req), .i_req_valid(vld), .o_rdata(rdata), .i_strap_in(pin),
		.i_clk_drive(clk_pattern),
		.o_strap_out(sout), .o_strap_oe(soe), .o_cfg(cfg), .o_freq_select(fsel));
	strap_board_model #(.PULL(PULL)) i_strap_board_model (.i_out(sout), .i_oe(soe), .o_pin(pin));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One write, valid held for exactly one edge, then one idle edge before the next
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req = '{wr: 1'b1, addr: a, wdata: d};
		vld = 1'b1;
		@(posedge clock);
		#1 vld = 1'b0;
		@(posedge clock);
		#1;
	endtask
	// Read answers one edge after the address is shown
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		req = '{wr: 1'b0, addr: a, wdata: 8'h00};
		@(posedge clock);
		#1 chk("rdata", {24'h0, exp}, {24'h0, rdata});
	endtask
	task automatic test_done();
		if (fail_count == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Watchdog: the sequence needs well under 400 cycles
	initial begin
		#20000;
		fail_count++;
		test_done();
	end
	initial begin
		fail_count = 0;
		check_count = 0;
		resetn = 1'b0;
		vld = 1'b0;
		clk_pattern = 5'h00;
		req = '{wr: 1'b0, addr: 8'h00, wdata: 8'h00};
		repeat (6) @(posedge clock);
		#1 resetn = 1'b1;
		repeat (110) @(posedge clock);
		pattern_seen = clk_pattern;
		#1 chk("fsel", {28'h0, PULL[3:0]}, {28'h0, fsel});
		chk("oe", 32'h1F, {27'h0, soe});
		chk("pin", {27'h0, pattern_seen}, {27'h0, pin});
		wr(8'h10, 8'hAA);
		rd(8'h10, {3'h0, PULL});
		chk("n_total", 32'h1E, {21'h0, cfg.n_total});
		rd(8'h15, 8'h00);
		rd(8'h30, 8'h00);
		wr(8'h0A, 8'h80);
		wr(8'h0F, 8'h41);
		wr(8'h10, 8'hFF);
		wr(8'h11, 8'hA5);
		wr(8'h12, 8'hFF);
		wr(8'h13, 8'h52);
		wr(8'h14, 8'hFF);
		wr(8'h15, 8'h5A);
		wr(8'h00, 8'h83);
		rd(8'h12, 8'h7F);
		rd(8'h14, 8'h0F);
		rd(8'h15, 8'h5A);
		rd(8'h10, 8'hFF);
		rd(8'h0F, 8'h41);
		rd(8'h11, 8'hA5);
		rd(8'h13, 8'h52);
		rd(8'h0A, 8'h80);
		rd(8'h00, 8'h83);
		chk("n_total", 32'h307, {21'h0, cfg.n_total});
		chk("m_total", 32'h3, {25'h0, cfg.m_total});
		chk("spread", 32'h7FA5, {17'h0, cfg.spread_percent_code});
		chk("cpu", 32'h5, {28'h0, cfg.processor_clock_divider});
		chk("link", 32'h2, {28'h0, cfg.link_clock_divider});
		chk("pci", 32'h4, {27'h0, cfg.pci_divider});
		chk("ref_div", 32'hF, {28'h0, cfg.serdes_ref_output_divider});
		chk("fsel", 32'h3, {28'h0, fsel});
		wr(8'h13, 8'hFF);
		repeat (2) @(posedge clock);
		#1 chk("pci", 32'h1E, {27'h0, cfg.pci_divider});
		// Mid-run reset: defaults return, straps are taken anew, early writes are refused
		resetn = 1'b0;
		#1 chk("oe", 32'h0, {27'h0, soe});
		repeat (6) @(posedge clock);
		#1 resetn = 1'b1;
		repeat (2) @(posedge clock);
		#1 wr(8'h13, 8'hFF);
		repeat (106) @(posedge clock);
		#1 chk("fsel", {28'h0, PULL[3:0]}, {28'h0, fsel});
		chk("oe", 32'h1F, {27'h0, soe});
		rd(8'h13, 8'h11);
		rd(8'h0A, 8'h00);
		rd(8'h0F, {3'h0, PULL});
		test_done();
	end
endmodule
